// file: hw/cocm_pkg.sv
package cocm_pkg;

    // -----------------------------------------------------------------
    // Frame geometry
    // -----------------------------------------------------------------
    // One frame is sixteen bits, most significant bit first.
    localparam int         FRAME_BITS = 16;
    localparam int         CNT_W      = 5;
    localparam logic [4:0] FRAME_LEN  = 5'h10;  // Bit count of a full frame.
    localparam logic [4:0] FRAME_OVER = 5'h11;  // Count saturates here.
    localparam int         CMD_POS    = 12;     // Command nibble at 15:12.
    localparam int         CMD_W      = 4;
    localparam int         DATA_W     = 12;     // Register data at 11:0.

    // -----------------------------------------------------------------
    // Command codes
    // -----------------------------------------------------------------
    // Command nibble values selecting the target of a frame.
    localparam logic [3:0] CMD_OPS    = 4'h1;   // Compact control frame.
    localparam logic [3:0] CMD_ON     = 4'h2;   // Write channel_on_bits.
    localparam logic [3:0] CMD_BANK_A = 4'h3;   // Write mode_bank_a.
    localparam logic [3:0] CMD_BANK_B = 4'h4;   // Write mode_bank_b.
    localparam logic [3:0] CMD_PAIR   = 4'h5;   // Write pair select bits.

    // -----------------------------------------------------------------
    // Channels and field positions
    // -----------------------------------------------------------------
    localparam int NUM_CH      = 10;  // Output channels 1 to 10.
    localparam int NUM_FB_CH   = 4;   // Channels 7 to 10 in the feedback.
    localparam int FB_CH_FIRST = 6;   // Index of channel 7.
    localparam int OPS_SET_POS = 4;   // Set bits 7:4, select bits 3:0.
    localparam int FB_POS      = 8;   // Feedback byte at 15:8 of reply.
    localparam int BANK_A_CH   = 6;   // Channels held in mode_bank_a.

    // -----------------------------------------------------------------
    // Reset values and masks
    // -----------------------------------------------------------------
    localparam logic [11:0] ON_BITS_RST = 12'hc00;  // Bits 11:10 stay one.
    localparam logic [11:0] BANK_A_RST  = 12'haaa;  // Every field is 10b.
    localparam logic [11:0] BANK_B_RST  = 12'h0aa;
    localparam logic [11:0] PAIR_RST    = 12'h000;
    localparam logic [11:0] ON_FIXED    = 12'hc00;  // Always-one bits.
    localparam logic [11:0] BANK_B_MASK = 12'h0ff;  // Bits 11:8 read zero.
    localparam logic [11:0] PAIR_MASK   = 12'h0f7;  // Only real pair bits.
    localparam logic [7:0]  OPS_RST     = 8'h00;
    localparam logic [7:0]  DIAG_BYTE   = 8'h00;    // Low reply byte.

endpackage : cocm_pkg

// file: hw/cocm_chan_sel.sv
`timescale 1ns/1ps

// Selects the raw control of one channel from its mode field.
module cocm_chan_sel (
    input  wire logic [1:0] channel_mode_field, // Two-bit mode of channel.
    input  wire logic       on_bit,             // Serial on/off bit.
    input  wire logic       channel_input_pin,  // Direct input pin level.
    output logic            ctrl                // Resulting raw control.
);

    // -----------------------------------------------------------------
    // Mode decode
    // -----------------------------------------------------------------
    // Serial for 0x, pin for 10, AND of both for 11.
    always_comb begin
        case (channel_mode_field)
            2'b10: ctrl = channel_input_pin;
            2'b11: ctrl = on_bit & channel_input_pin;
            default: ctrl = on_bit;
        endcase
    end

endmodule // cocm_chan_sel

// file: hw/cocm_ctrl.sv
`timescale 1ns/1ps

// Overview of operation
// - Reply bits 15:8 carry the eight-bit pin feedback byte.
// - Serial-selected channels 7-10 echo set bits from the previous frame.
// - Parallel-selected channels 7-10 report input pin at chip select fall.
// - Serial or parallel feedback is chosen per channel independently.
// - Output data bits 9:0 switch channels 1-10 on when one.
// - Output data bit governs a channel in every mode except mode 10.
// - Output data resets to C00 hex; bits 11:10 always read one.
// - Mode 10 switches the channel directly from its input pin.
// - Mode 11 turns the channel on when data bit and pin are one.
// - Mode fields reset to 10; bank A AAA hex, bank B 0AA hex.
// - Bank A holds channels 1-6; bank B channels 7-10, bits 11:8 zero.
// - A set pair bit drives both channels from the lower channel.
// - Pair bit zero is direct, one pairs with next channel; reset 000.
// - Pairing only inside groups 1-4, 5-6 and 7-10.
// - Second command byte decides the first reply byte of next frame.
module cocm_ctrl (
    input  wire logic       ref_clk,           // System clock, 100 MHz.
    input  wire logic       rstn,              // Asynchronous reset, low.
    input  wire logic       sclk,              // Serial clock from host.
    input  wire logic       cs_n,              // Chip select, active low.
    input  wire logic       si,                // Serial data in.
    output logic            so,                // Serial data out.
    output logic            so_oe,             // Serial out drive enable.
    input  wire logic [9:0] channel_input_pin, // Direct pins, ch 1 to 10.
    output logic [9:0]      chan_out           // Channel on controls.
);

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    typedef struct packed {
        logic        sclk_d;        // Serial clock of the last cycle.
        logic        cs_d;          // Chip select of the last cycle.
        logic [15:0] in_shift;      // Received frame bits.
        logic [4:0]  bit_cnt;       // Rising edges seen in this frame.
        logic [15:0] out_shift;     // Reply bits still to send.
        logic        so;            // Serial out flop.
        logic        so_oe;         // Serial out enable flop.
        logic [11:0] on_bits;       // channel_on_bits register.
        logic [11:0] bank_a;        // mode_bank_a register.
        logic [11:0] bank_b;        // mode_bank_b register.
        logic [11:0] pair;          // pair_select_bit register.
        logic [7:0]  prev_ops;      // pin_set_byte of the last compact frame.
        logic [9:0]  chan_out;      // Registered channel controls.
    } cocm_state_s;

    cocm_state_s st;
    cocm_state_s next_st;

    logic [9:0]  raw_ctrl;
    logic [9:0]  eff_ctrl;
    logic [8:0]  link;
    logic [19:0] modes;
    logic [7:0]  fb_byte;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        frame_done;
    logic [3:0]  cmd;

    // -----------------------------------------------------------------
    // Edge detection on the serial pins
    // -----------------------------------------------------------------
    // Pins are synchronous to ref_clk, so edges come from one delay flop.
    assign sclk_rise  = sclk & ~st.sclk_d;
    assign sclk_fall  = ~sclk & st.sclk_d;
    assign cs_fall    = ~cs_n & st.cs_d;
    assign cs_rise    = cs_n & ~st.cs_d;
    assign frame_done = cs_rise && (st.bit_cnt == cocm_pkg::FRAME_LEN);
    assign cmd        = st.in_shift[cocm_pkg::CMD_POS +: cocm_pkg::CMD_W];

    // -----------------------------------------------------------------
    // Channel mode selection
    // -----------------------------------------------------------------
    // Bank A holds channels 1 to 6, bank B channels 7 to 10.
    assign modes = {st.bank_b[7:0], st.bank_a[11:0]};

    // One selector per channel turns mode, data bit and pin into control.
    genvar g;
    generate
        for (g = 0; g < cocm_pkg::NUM_CH; g++) begin : g_chan
            cocm_chan_sel u_sel (
                .channel_mode_field (modes[2*g+1:2*g]),
                .on_bit             (st.on_bits[g]),
                .channel_input_pin  (channel_input_pin[g]),
                .ctrl               (raw_ctrl[g])
            );
        end
    endgenerate

    // -----------------------------------------------------------------
    // Parallel pairing
    // -----------------------------------------------------------------
    // Links join a channel to the next; none crosses 4-5 or 6-7.
    assign link = {st.pair[7], st.pair[6], st.pair[5], 1'b0,
                   st.pair[4], 1'b0, st.pair[2], st.pair[1],
                   st.pair[0]};

    // A linked channel copies the control of the channel below it.
    always_comb begin
        eff_ctrl[0] = raw_ctrl[0];
        for (int i = 1; i < cocm_pkg::NUM_CH; i++) begin
            eff_ctrl[i] = link[i-1] ? eff_ctrl[i-1] : raw_ctrl[i];
        end
    end

    // -----------------------------------------------------------------
    // Pin feedback byte
    // -----------------------------------------------------------------
    // Each channel 7-10 picks echo or sampled pin on its own select bit.
    always_comb begin
        fb_byte[3:0] = st.prev_ops[3:0];
        for (int i = 0; i < cocm_pkg::NUM_FB_CH; i++) begin
            fb_byte[cocm_pkg::OPS_SET_POS+i] = st.prev_ops[i]
                ? channel_input_pin[cocm_pkg::FB_CH_FIRST+i]
                : st.prev_ops[cocm_pkg::OPS_SET_POS+i];
        end
    end

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    // Shifts the frame, builds the reply and commits complete frames.
    always_comb begin
        next_st          = st;
        next_st.sclk_d   = sclk;
        next_st.cs_d     = cs_n;
        next_st.so_oe    = ~cs_n;
        next_st.chan_out = eff_ctrl;
        if (cs_fall) begin
            next_st.bit_cnt   = '0;
            next_st.out_shift = {fb_byte, cocm_pkg::DIAG_BYTE};
            next_st.so        = fb_byte[7];
        end else if (!cs_n) begin
            if (sclk_rise) begin
                next_st.in_shift = {st.in_shift[14:0], si};
                if (st.bit_cnt != cocm_pkg::FRAME_OVER) begin
                    next_st.bit_cnt = st.bit_cnt + 5'h1;
                end
            end
            if (sclk_fall) begin
                next_st.out_shift = {st.out_shift[14:0], 1'b0};
                next_st.so        = st.out_shift[14];
            end
        end
        // Only a frame of exactly sixteen bits reaches the registers.
        if (frame_done) begin
            if (cmd == cocm_pkg::CMD_OPS) begin
                next_st.prev_ops = st.in_shift[7:0];
                for (int i = 0; i < cocm_pkg::NUM_FB_CH; i++) begin
                    if (!st.in_shift[i]) begin
                        next_st.on_bits[cocm_pkg::FB_CH_FIRST+i] =
                            st.in_shift[cocm_pkg::OPS_SET_POS+i];
                    end
                end
            end else if (cmd == cocm_pkg::CMD_ON) begin
                next_st.on_bits = st.in_shift[11:0]
                                | cocm_pkg::ON_FIXED;
            end else if (cmd == cocm_pkg::CMD_BANK_A) begin
                next_st.bank_a = st.in_shift[11:0];
            end else if (cmd == cocm_pkg::CMD_BANK_B) begin
                next_st.bank_b = st.in_shift[11:0]
                               & cocm_pkg::BANK_B_MASK;
            end else if (cmd == cocm_pkg::CMD_PAIR) begin
                next_st.pair = st.in_shift[11:0]
                             & cocm_pkg::PAIR_MASK;
            end
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    // Reset puts every register at its documented default.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st.sclk_d    <= 1'b0;
            st.cs_d      <= 1'b1;
            st.in_shift  <= 16'h0000;
            st.bit_cnt   <= 5'h00;
            st.out_shift <= 16'h0000;
            st.so        <= 1'b0;
            st.so_oe     <= 1'b0;
            st.on_bits   <= cocm_pkg::ON_BITS_RST;
            st.bank_a    <= cocm_pkg::BANK_A_RST;
            st.bank_b    <= cocm_pkg::BANK_B_RST;
            st.pair      <= cocm_pkg::PAIR_RST;
            st.prev_ops  <= cocm_pkg::OPS_RST;
            st.chan_out  <= 10'h000;
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // All outputs come straight from the state flops.
    assign so       = st.so;
    assign so_oe    = st.so_oe;
    assign chan_out = st.chan_out;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_cs_fall;
        !cs_n && st.cs_d;
    endsequence

    sequence s_short_frame;
        cs_n && !st.cs_d && (st.bit_cnt != cocm_pkg::FRAME_LEN);
    endsequence

    sequence s_frame_end;
        cs_n && !st.cs_d && (st.bit_cnt == cocm_pkg::FRAME_LEN);
    endsequence

    sequence s_sclk_fall;
        !cs_n && !st.cs_d && !sclk && st.sclk_d;
    endsequence

    a_fixed_one_bits: assert property (
        st.on_bits[11:10] == 2'b11)
        else $error("Output data bits 11:10 are not one.");

    a_bank_b_upper: assert property (
        st.bank_b[11:8] == 4'h0)
        else $error("Mode bank B upper bits are not zero.");

    a_pair_groups: assert property (
        st.pair[3] == 1'b0 && st.pair[11:8] == 4'h0)
        else $error("Pair bit crosses a channel group.");

    a_serial_mode: assert property (
        st.bank_a[1] == 1'b0 |=> st.chan_out[0] == $past(st.on_bits[0]))
        else $error("Channel 1 ignores its data bit in serial mode.");

    a_input_mode: assert property (
        st.bank_a[1:0] == 2'b10
        |=> st.chan_out[0] == $past(channel_input_pin[0]))
        else $error("Channel 1 does not follow its pin in input mode.");

    a_and_mode: assert property (
        st.bank_a[1:0] == 2'b11 |=> st.chan_out[0] ==
        ($past(st.on_bits[0]) & $past(channel_input_pin[0])))
        else $error("Channel 1 is not the AND of data and pin.");

    a_pair_follow: assert property (
        st.pair[0] |=> st.chan_out[1] == st.chan_out[0])
        else $error("Paired channel 2 differs from channel 1.");

    a_fb_parallel: assert property (
        s_cs_fall ##0 st.prev_ops[0]
        |=> st.out_shift[12] == $past(channel_input_pin[6]))
        else $error("Parallel feedback bit is not the sampled pin.");

    a_fb_serial: assert property (
        s_cs_fall ##0 !st.prev_ops[0]
        |=> st.out_shift[12] == $past(st.prev_ops[4]))
        else $error("Serial feedback bit is not the echoed set bit.");

    a_short_frame: assert property (
        s_short_frame |=> $stable(st.on_bits) && $stable(st.bank_a)
        && $stable(st.bank_b) && $stable(st.pair))
        else $error("Registers changed after a partial frame.");

    // Reply framing: drive enable, first bit, later bits and fixed fields.
    a_drive_enable: assert property (
        st.so_oe == !$past(cs_n))
        else $error("Serial out enable does not follow chip select.");

    a_reply_start: assert property (
        s_cs_fall |=> st.so == st.out_shift[15])
        else $error("First reply bit is not the feedback top bit.");

    a_select_echo: assert property (
        s_cs_fall |=> st.out_shift[11:8] == $past(st.prev_ops[3:0])
        && st.out_shift[7:0] == cocm_pkg::DIAG_BYTE)
        else $error("Reply select bits or low byte are wrong.");

    a_reply_shift: assert property (
        s_sclk_fall |=> st.so == $past(st.out_shift[14]))
        else $error("Reply bit did not advance on a clock fall.");

    a_frame_start: assert property (
        s_cs_fall |=> st.bit_cnt == 5'h00)
        else $error("Bit count did not restart at chip select fall.");

    // Channel 10 feedback picks its source on its own select bit.
    a_fb_ch10: assert property (
        s_cs_fall |=> st.out_shift[15] == ($past(st.prev_ops[3])
        ? $past(channel_input_pin[9]) : $past(st.prev_ops[7])))
        else $error("Channel 10 feedback ignores its select bit.");

    // Channel 10 input mode, upper pairs and the group edge at 6-7.
    a_input_mode_b: assert property (
        st.bank_b[7:6] == 2'b10 && !st.pair[7]
        |=> st.chan_out[9] == $past(channel_input_pin[9]))
        else $error("Channel 10 does not follow its pin in input mode.");

    a_pair_chain: assert property (
        st.pair[7] |=> st.chan_out[9] == st.chan_out[8])
        else $error("Paired channel 10 differs from channel 9.");

    a_group_edge: assert property (
        st.bank_b[1] == 1'b0 |=> st.chan_out[6] == $past(st.on_bits[6]))
        else $error("Channel 7 does not follow its own data bit.");

    // Register writes land one cycle after a complete frame.
    a_on_write: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_ON) |=> st.on_bits ==
        ($past(st.in_shift[11:0]) | cocm_pkg::ON_FIXED))
        else $error("Output data write did not land.");

    a_bank_a_write: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_BANK_A)
        |=> st.bank_a == $past(st.in_shift[11:0]))
        else $error("Mode bank A write did not land.");

    a_bank_b_write: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_BANK_B) |=> st.bank_b ==
        ($past(st.in_shift[11:0]) & cocm_pkg::BANK_B_MASK))
        else $error("Mode bank B write did not land.");

    a_pair_write: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_PAIR) |=> st.pair ==
        ($past(st.in_shift[11:0]) & cocm_pkg::PAIR_MASK))
        else $error("Pair select write did not land.");

    a_set_byte_store: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_OPS)
        |=> st.prev_ops == $past(st.in_shift[7:0]))
        else $error("Set byte of a compact frame was not kept.");

    a_ops_on_bits: assert property (
        s_frame_end ##0 (cmd == cocm_pkg::CMD_OPS) ##0 !st.in_shift[0]
        |=> st.on_bits[6] == $past(st.in_shift[4]))
        else $error("Serial-selected set bit missed channel 7 data.");

endmodule // cocm_ctrl

// file: verification/cocm_host_model.sv
`timescale 1ns/1ps

// Host side of the serial link: sends frames and collects the reply.
module cocm_host_model (
    input  wire logic ref_clk, // System clock.
    output logic      sclk,    // Serial clock, idle low.
    output logic      cs_n,    // Chip select, active low.
    output logic      si,      // Serial data to the block.
    input  wire logic so       // Serial data from the block.
);
    // Lines start idle between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // Sends nbits MSB first with chip select low for the whole frame.
    // Each clock phase lasts half cycles (two at least, so the reply
    // bit has settled); it is taken just before each rising edge.
    // Diagnosis of paired channels would be ORed here; none is sent.
    task automatic xfer(
        input  logic [15:0] tx,
        input  int          nbits,
        input  int          half,
        output logic [15:0] rx
    );
        int          i;
        logic [15:0] sh;
        rx = 16'h0000;
        sh = tx;
        @(posedge ref_clk);
        cs_n <= 1'b0;
        si   <= sh[15];
        repeat (half) @(posedge ref_clk);
        for (i = 0; i < nbits; i++) begin
            @(posedge ref_clk);
            rx[15 - i] = so;
            sclk <= 1'b1;
            repeat (half) @(posedge ref_clk);
            sh = {sh[14:0], ~sh[0]};
            sclk <= 1'b0;
            si   <= sh[15];
            repeat (half - 1) @(posedge ref_clk);
        end
        repeat (half) @(posedge ref_clk);
        cs_n <= 1'b1;
        si   <= ~si; // Released line shows no stale level.
        repeat (3) @(posedge ref_clk);
    endtask
endmodule // cocm_host_model

// file: verification/channel_output_mode_control_tb.sv
`timescale 1ns/1ps

module channel_output_mode_control_tb;
    logic        ref_clk;
    logic        rstn;
    logic        sclk;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [9:0]  pins;
    logic [9:0]  chan_out;
    logic [15:0] rx;
    logic [7:0]  prev;
    logic [17:0] step;
    logic [7:0]  exp_fb;
    logic [3:0]  on_hi;
    int          mismatches;
    int          n_tests;
    int          k;
    int          j;

    cocm_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk),
        .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
        .channel_input_pin(pins), .chan_out(chan_out));
    cocm_host_model host_u (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
        .si(si), .so(so));

    // ----------------------------------------------------------------
    // Clock and helpers
    // ----------------------------------------------------------------
    // Free-running 100 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Counts one comparison and reports a difference at once.
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One frame, then time for the commit to reach the channels.
    task automatic frame(input logic [3:0] cmd, input logic [11:0] data,
                         input int nbits, input int half);
        host_u.xfer({cmd, data}, nbits, half, rx);
        repeat (2) @(posedge ref_clk);
    endtask

    // Changes the direct pins and lets the channels follow.
    task automatic set_pins(input logic [9:0] v);
        @(posedge ref_clk);
        pins <= v;
        repeat (3) @(posedge ref_clk);
    endtask

    // Expected feedback byte from the last control byte and the pins.
    function automatic logic [7:0] fb(input logic [7:0] p,
                                      input logic [9:0] in);
        int i;
        fb = p;
        for (i = 0; i < 4; i++) begin
            fb[4 + i] = p[i] ? in[6 + i] : p[4 + i];
        end
    endfunction

    // Compact control byte and pin levels for each feedback step.
    function automatic logic [17:0] fb_step(input int n);
        case (n)
            0: fb_step = {8'ha5, 10'h140};
            1: fb_step = {8'h0f, 10'h3c0};
            2: fb_step = {8'hf0, 10'h000};
            3: fb_step = {8'h3c, 10'h2c0};
            default: fb_step = {8'h00, 10'h1c0};
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    // Bounded run time; running out counts as a failure.
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        $display("MISMATCH at %0t: run did not finish", $time);
        stop_test();
    end

    // Main sequence of frames and expected channel states.
    initial begin
        rstn = 1'b0;
        pins = 10'h000;
        mismatches = 0;
        n_tests = 0;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        set_pins(10'h2a5);
        check({6'h00, chan_out}, 16'h02a5, "reset pin mode");
        check({15'h0000, so_oe}, 16'h0000, "idle enable");
        frame(cocm_pkg::CMD_BANK_A, 12'h555, 16, 3);
        frame(cocm_pkg::CMD_BANK_B, 12'hf00, 16, 3);
        check({6'h00, chan_out}, 16'h0000, "reset data");
        frame(cocm_pkg::CMD_ON, 12'h155, 16, 3);
        check({6'h00, chan_out}, 16'h0155, "serial mode");
        $display("test serial done");
        frame(cocm_pkg::CMD_ON, 12'h2aa, 12, 3);
        frame(4'h9, 12'h3ff, 16, 3);
        check({6'h00, chan_out}, 16'h0155, "refused frames");
        $display("test refusal done");
        frame(cocm_pkg::CMD_BANK_A, 12'hfff, 16, 3);
        frame(cocm_pkg::CMD_BANK_B, 12'h0ff, 16, 3);
        set_pins(10'h3c3);
        check({6'h00, chan_out}, 16'h0141, "and mode");
        frame(cocm_pkg::CMD_BANK_A, 12'haaa, 16, 3);
        frame(cocm_pkg::CMD_BANK_B, 12'h0aa, 16, 3);
        check({6'h00, chan_out}, 16'h03c3, "pin mode");
        $display("test modes done");
        frame(cocm_pkg::CMD_BANK_A, 12'h000, 16, 7);
        frame(cocm_pkg::CMD_BANK_B, 12'h000, 16, 7);
        frame(cocm_pkg::CMD_ON, 12'h061, 16, 7);
        frame(cocm_pkg::CMD_PAIR, 12'hfff, 16, 7);
        check({6'h00, chan_out}, 16'h03cf, "paired");
        frame(cocm_pkg::CMD_PAIR, 12'h000, 16, 7);
        check({6'h00, chan_out}, 16'h0061, "direct");
        $display("test pairing done");
        prev = 8'h00;
        on_hi = 4'h1;
        for (k = 0; k < 5; k++) begin
            step = fb_step(k);
            set_pins(step[9:0]);
            fork
                frame(cocm_pkg::CMD_OPS, {4'h0, step[17:10]}, 16, 3);
                begin
                    repeat (6) @(posedge ref_clk);
                    pins <= ~step[9:0];
                    check({15'h0000, so_oe}, 16'h0001, "enable");
                end
            join
            exp_fb = fb(prev, step[9:0]);
            check({12'h000, rx[15:12]}, {12'h000, exp_fb[7:4]},
                  "feedback pins");
            check({12'h000, rx[11:8]}, {12'h000, exp_fb[3:0]},
                  "feedback selects");
            check({8'h00, rx[7:0]}, 16'h0000, "low reply byte");
            for (j = 0; j < 4; j++) begin
                if (!step[10 + j]) begin
                    on_hi[j] = step[14 + j];
                end
            end
            check({6'h00, chan_out}, {6'h00, on_hi, 6'h21},
                  "compact data");
            prev = step[17:10];
        end
        $display("test feedback done");
        stop_test();
    end
endmodule // channel_output_mode_control_tb
